// ### bes_sampling_ctrl.sv
// Back-EMF sampling controller: PWM shaping, sample timing, Z filter
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Default sensorless: sample at end of off-time
// - Current mode PWM: window, comparator, minimum off
// - Voltage mode PWM from 12-bit compare
// - Current limit switches PWM off immediately
// - Demag sampling always at sample clock
// - Hall mode: no demag, sample clock
// - High-rate bit: sample clock after demag
// - High-rate forces zero off-time, full duty
// - Nonzero delay: step 2.5 us per count
// - Delay, low rate: one on-time sample
// - Nonzero delay forces zero off-time, full duty
// - Late sample discarded, flag, masked interrupt
// - Sample-out interrupt only with nonzero delay
// - High rate plus delay: window until off
// - Sampling type applies after demag only
// - Outputs off: demag continues, Z per bit in sensorless low rate
// - Off-time sampling grounds or floats inputs
// - Zero-crossing counter active only while Z samples are taken
// - Filter count sets consecutive samples needed
module bes_sampling_ctrl
  import bes_pkg::*;
(
  input  wire logic       i_ref_clk,          // Peripheral clock
  input  wire logic       i_arst_n,           // Asynchronous reset
  input  wire logic [3:0] i_addr,             // Register index
  input  wire logic [7:0] i_wdata,            // Write data
  input  wire logic       i_wr,               // Write strobe
  input  wire logic       i_rd,               // Read strobe
  input  wire logic       i_phase_cmp,        // Phase comparator pin
  input  wire logic       i_rotor_input_a,    // Hall input a
  input  wire logic       i_rotor_input_b,    // Hall input b
  input  wire logic       i_rotor_input_c,    // Hall input c
  input  wire logic       i_cur_limit,        // Current comparator pin
  input  wire logic       i_commutate,        // Commutation pulse
  input  wire logic       i_demag_event,      // Demag found pulse
  output logic [7:0]      o_rdata,            // Read data
  output logic            o_pwm,              // Sampling PWM signal
  output logic            o_d_sample,         // Demag sample strobe
  output logic            o_z_sample,         // Z sample strobe
  output logic            o_zc_event,         // Hardware Z event
  output logic [3:0]      o_zc_count,         // Consecutive Z samples
  output logic            o_sample_out_irq,   // Sample-out request
  output logic            o_off_input_ground, // Ground off inputs
  output logic            o_off_input_hiz     // Float off inputs
);

  bes_state_t r_reg;   // Registered state
  bes_state_t r_next;  // Next state

  // Decoded control bits
  logic       sensor;    // Hall mode
  logic       high_rate; // High-rate zero-crossing sampling
  logic       dly_nz;    // A sample delay is programmed
  logic       min_off;   // Minimum off-time in force
  logic       tick;      // Sample clock tick
  logic       pwm_rise;  // PWM turn-on edge
  logic       z_allow;   // Zero-crossing sampling permitted
  logic       z_sel;     // Selected sampled level
  logic       z_due;     // Sampling instant for zero crossing
  logic       expire;    // Delay ends this cycle
  logic       z_take;    // Zero-crossing sample taken
  logic       late;      // Delayed sample fell outside on-time
  logic       cmp_a;     // Synchronised comparator
  logic       lim_a;     // Synchronised current limit
  logic [3:0] hall;      // Synchronised hall inputs, padded
  logic [8:0] win_len;   // Window period in cycles
  logic [4:0] scf_div;   // Sample clock divisor

  // Decode of configuration and derived strobes
  always_comb begin
    sensor    = r_reg.ctl_a[BES_A_SR];
    high_rate = r_reg.ctl_c[BES_C_HR];
    dly_nz    = (r_reg.dly != 4'h0);
    min_off   = ~sensor & ~high_rate & ~dly_nz;
    cmp_a     = r_reg.sync2[0];
    lim_a     = r_reg.sync2[4];
    hall      = {1'b0, r_reg.sync2[3:1]};
    z_sel     = sensor ? hall[r_reg.ctl_a[BES_A_HSEL +: 2]] : cmp_a;
    tick      = (r_reg.scf_cnt == 5'h00);
    scf_div   = 5'((BES_SCF_DIV0 + 5'h01) << r_reg.ctl_c[BES_C_SCF +: 2]);
    win_len   = 9'(BES_WIN_STEP * (9'(r_reg.win_sel) + 9'h001));
    pwm_rise  = r_reg.pwm & ~r_reg.pwm_prev;
    expire    = r_reg.dly_run & (r_reg.dcnt == 8'h01);
    // Idle outputs in sensorless low-rate mode obey the idle bit
    z_allow   = r_reg.ctl_a[BES_A_MOE] | sensor | high_rate |
                r_reg.sctl[BES_S_ZSV];
    if (sensor) begin
      z_due = tick;
    end else if (!dly_nz) begin
      // Off-time end is the cycle the PWM turns back on
      z_due = high_rate ? tick : pwm_rise;
    end else if (high_rate) begin
      z_due = r_reg.win_open & r_reg.pwm & tick;
    end else begin
      z_due = expire & r_reg.on_ok & r_reg.pwm;
    end
    // Sampling types act only after the demag event
    z_take = (r_reg.phase == PH_ZC) & z_allow & z_due;
    late   = (r_reg.phase == PH_ZC) & z_allow & ~sensor & dly_nz &
             expire & ~(r_reg.on_ok & r_reg.pwm);
  end

  // Next-state logic for the whole controller
  always_comb begin
    r_next          = r_reg;
    r_next.sync1    = {i_cur_limit, i_rotor_input_c, i_rotor_input_b,
                       i_rotor_input_a, i_phase_cmp};
    r_next.sync2    = r_reg.sync1;
    r_next.pwm_prev = r_reg.pwm;
    r_next.rdata    = 8'h00;
    r_next.d_smp    = 1'b0;
    r_next.z_smp    = 1'b0;
    r_next.z_evt    = 1'b0;

    // Register writes
    if (i_wr) begin
      case (i_addr)
        BES_ADDR_CTRL_A: r_next.ctl_a = i_wdata[4:0];
        BES_ADDR_CTRL_C: r_next.ctl_c = i_wdata[3:0];
        BES_ADDR_CONF: begin
          r_next.dly = i_wdata[BES_CONF_DS +: 4];
          r_next.sample_out_int_mask = i_wdata[BES_CONF_SOM];
          // Writing zero clears the flag, one leaves it
          if (!i_wdata[BES_CONF_SOF]) begin
            r_next.sof = 1'b0;
          end
        end
        BES_ADDR_SCTRL:  r_next.sctl = i_wdata[1:0];
        BES_ADDR_ZFILT:  r_next.zef = i_wdata[3:0];
        BES_ADDR_PWMTIM: begin
          r_next.win_sel = i_wdata[3:0];
          r_next.off_sel = i_wdata[7:4];
        end
        BES_ADDR_CMP_LO: r_next.cmp[7:0] = i_wdata;
        BES_ADDR_CMP_HI: r_next.cmp[11:8] = i_wdata[3:0];
        default: begin
          // Unmapped and read-only indices ignore writes
        end
      endcase
    end

    // Register reads, data valid next cycle
    if (i_rd) begin
      case (i_addr)
        BES_ADDR_CTRL_A: r_next.rdata = {3'h0, r_reg.ctl_a};
        BES_ADDR_CTRL_C: r_next.rdata = {4'h0, r_reg.ctl_c};
        BES_ADDR_CONF:   r_next.rdata = {r_reg.sof, r_reg.sample_out_int_mask, 2'h0,
                                         r_reg.dly};
        BES_ADDR_SCTRL:  r_next.rdata = {6'h00, r_reg.sctl};
        BES_ADDR_ZFILT:  r_next.rdata = {4'h0, r_reg.zef};
        BES_ADDR_PWMTIM: r_next.rdata = {r_reg.off_sel, r_reg.win_sel};
        BES_ADDR_CMP_LO: r_next.rdata = r_reg.cmp[7:0];
        BES_ADDR_CMP_HI: r_next.rdata = {4'h0, r_reg.cmp[11:8]};
        BES_ADDR_STATUS: r_next.rdata = {r_reg.zcnt, r_reg.win_open,
                                         r_reg.pwm, r_reg.phase};
        default:         r_next.rdata = 8'h00;
      endcase
    end

    // Sample clock divider
    r_next.scf_cnt = tick ? 5'(scf_div - 5'h01) : 5'(r_reg.scf_cnt - 5'h01);

    // PWM generation
    if (r_reg.ctl_a[BES_A_CURMODE]) begin
      // Current mode: window start turns on, comparator turns off
      r_next.wcnt = (r_reg.wcnt >= 9'(win_len - 9'h001)) ? 9'h000 :
                    9'(r_reg.wcnt + 9'h001);
      if (r_reg.ocnt != 6'h00) begin
        r_next.ocnt = 6'(r_reg.ocnt - 6'h01);
      end
      if (lim_a) begin
        r_next.pwm  = 1'b0;
        if (r_reg.pwm) begin
          // Stabilisation off-time, zero when not in force
          r_next.ocnt = min_off ?
                        6'(BES_OFF_STEP * 6'(r_reg.off_sel)) :
                        6'h00;
        end
      end else if ((r_reg.wcnt == 9'h000) && (r_reg.ocnt == 6'h00)) begin
        r_next.pwm = 1'b1;
      end
    end else begin
      // Voltage mode: 12-bit compare, limit holds off to period end
      r_next.vcnt = 12'(r_reg.vcnt + 12'h001);
      if (r_reg.vcnt == BES_PWM_MAX) begin
        r_next.lim = 1'b0;
      end else if (lim_a) begin
        r_next.lim = 1'b1;
      end
      r_next.pwm = ((r_reg.vcnt < r_reg.cmp) ||
                    ((r_reg.cmp == BES_PWM_MAX) && !min_off)) &&
                   !(min_off && (r_reg.vcnt >=
                     12'(BES_PWM_MAX - 12'(BES_OFF_STEP) *
                         12'(r_reg.off_sel)))) &&
                   !lim_a && !r_reg.lim;
    end

    // Sample delay counted from each turn-on edge
    if (pwm_rise && dly_nz) begin
      r_next.dcnt    = 8'(BES_DS_STEP * 8'(r_reg.dly));
      r_next.dly_run = 1'b1;
      r_next.on_ok   = 1'b1;
    end else if (r_reg.dly_run) begin
      r_next.dcnt = 8'(r_reg.dcnt - 8'h01);
      if (!r_reg.pwm) begin
        r_next.on_ok = 1'b0;
      end
      if (expire) begin
        r_next.dly_run  = 1'b0;
        r_next.win_open = high_rate & r_reg.on_ok & r_reg.pwm;
      end
    end
    // The window closes at the next off-time
    if (!r_reg.pwm || !dly_nz) begin
      r_next.win_open = 1'b0;
    end

    // Step phase sequencing
    case (r_reg.phase)
      PH_DEMAG: begin
        // Demag sampling ignores the PWM state
        r_next.d_smp = ~sensor & tick;
        if (sensor || i_demag_event) begin
          r_next.phase = PH_ZC;
        end
      end
      PH_ZC:   r_next.phase = PH_ZC;
      PH_DONE: r_next.phase = PH_DONE;
      default: r_next.phase = PH_DEMAG;
    endcase

    // Consecutive sample counter and filter
    r_next.z_smp = z_take;
    if (z_take) begin
      if (z_sel == r_reg.ctl_c[BES_C_ZLVL]) begin
        if (r_reg.zcnt >= r_reg.zef) begin
          r_next.z_evt = 1'b1;
          r_next.zcnt  = 4'h0;
          r_next.phase = PH_DONE;
        end else begin
          r_next.zcnt = 4'(r_reg.zcnt + 4'h1);
        end
      end else begin
        r_next.zcnt = 4'h0;
      end
    end

    // Commutation restarts the step
    if (i_commutate) begin
      r_next.phase = sensor ? PH_ZC : PH_DEMAG;
      r_next.zcnt  = 4'h0;
    end

    // Late sample: discarded and flagged, set wins over clear
    if (late) begin
      r_next.sof = 1'b1;
    end
    r_next.irq = r_next.sof & r_next.sample_out_int_mask &
                 (r_next.dly != 4'h0);

    // Off-state input handling for end-of-off-time sampling
    r_next.gnd = min_off & ~r_next.sctl[BES_S_OFF_INPUT_STATE_SELECT];
    r_next.hiz = min_off & r_next.sctl[BES_S_OFF_INPUT_STATE_SELECT];
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r_reg         <= '0;
      r_reg.ctl_a   <= BES_RST_REG[4:0];
      r_reg.cmp     <= BES_RST_CMP;
      r_reg.phase   <= PH_DEMAG;
      r_reg.scf_cnt <= BES_SCF_DIV0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from flip-flops
  always_comb begin
    o_rdata            = r_reg.rdata;
    o_pwm              = r_reg.pwm;
    o_d_sample         = r_reg.d_smp;
    o_z_sample         = r_reg.z_smp;
    o_zc_event         = r_reg.z_evt;
    o_zc_count         = r_reg.zcnt;
    o_sample_out_irq   = r_reg.irq;
    o_off_input_ground = r_reg.gnd;
    o_off_input_hiz    = r_reg.hiz;
  end

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  a_eof_sample: assert property (
    min_off && !r_reg.ctl_a[BES_A_SR] && r_reg.phase == PH_ZC &&
    z_allow && pwm_rise |=> o_z_sample)
    else $error("end of off-time sample missing");
  a_demag_rate: assert property (
    r_reg.phase == PH_DEMAG && !sensor && tick |=> o_d_sample)
    else $error("demag sample missing on tick");
  a_hall_nodemag: assert property (
    sensor |=> !o_d_sample)
    else $error("demag sampled in hall mode");
  a_delay_steps: assert property (
    pwm_rise && dly_nz && !i_wr |=> r_reg.dcnt == 8'(10 * r_reg.dly))
    else $error("delay count not ten per step");
  a_zero_off: assert property (
    (dly_nz || high_rate) |=> !o_off_input_ground && !o_off_input_hiz)
    else $error("minimum off-time still in force");
  a_late_flag: assert property (
    late |=> r_reg.sof)
    else $error("sample-out flag not set");
  a_late_drop: assert property (
    late |=> !o_z_sample)
    else $error("late sample was taken");
  a_irq_gate: assert property (
    o_sample_out_irq |-> r_reg.dly != 4'h0)
    else $error("interrupt without delay");
  a_before_demag: assert property (
    r_reg.phase == PH_DEMAG |=> !o_z_sample)
    else $error("zero crossing sampled before demag");
  a_filter_evt: assert property (
    z_take && z_sel == r_reg.ctl_c[BES_C_ZLVL] &&
    r_reg.zcnt < r_reg.zef |=> !o_zc_event)
    else $error("event before filter count");
  a_limit_off: assert property (
    lim_a && !i_wr |=> !o_pwm)
    else $error("pwm not off at current limit");
  a_no_offtime: assert property (
    r_reg.ctl_a[BES_A_CURMODE] && lim_a && r_reg.pwm &&
    (dly_nz || high_rate) |=> r_reg.ocnt == 6'h00)
    else $error("stabilisation off-time loaded");
  a_cur_on: assert property (
    r_reg.ctl_a[BES_A_CURMODE] && !lim_a && r_reg.wcnt == 9'h000 &&
    r_reg.ocnt == 6'h00 |=> o_pwm)
    else $error("pwm not on at window start");
  a_cmp_off: assert property (
    !r_reg.ctl_a[BES_A_CURMODE] && r_reg.vcnt >= r_reg.cmp &&
    r_reg.cmp != BES_PWM_MAX |=> !o_pwm)
    else $error("pwm on past compare value");
  a_hr_tick: assert property (
    high_rate && !dly_nz && !sensor && r_reg.phase == PH_ZC &&
    z_allow && tick |=> o_z_sample)
    else $error("high-rate sample missing on tick");
  a_on_only: assert property (
    z_take && dly_nz && !sensor |-> r_reg.pwm)
    else $error("delayed sample outside on-time");
  a_window_close: assert property (
    !r_reg.pwm |=> !r_reg.win_open)
    else $error("sampling window open in off-time");
  a_idle_stop: assert property (
    !r_reg.ctl_a[BES_A_MOE] && !sensor && !high_rate &&
    !r_reg.sctl[BES_S_ZSV] |=> !o_z_sample)
    else $error("zero crossing sampled while idle");
  a_gnd_select: assert property (
    min_off && !r_reg.sctl[BES_S_OFF_INPUT_STATE_SELECT] && !i_wr |=> o_off_input_ground)
    else $error("off inputs not grounded");
  a_filter_done: assert property (
    z_take && z_sel == r_reg.ctl_c[BES_C_ZLVL] &&
    r_reg.zcnt >= r_reg.zef |=> o_zc_event)
    else $error("event missing at filter count");
  a_count_clear: assert property (
    z_take && z_sel != r_reg.ctl_c[BES_C_ZLVL] |=> o_zc_count == 4'h0)
    else $error("count not cleared on mismatch");

endmodule : bes_sampling_ctrl
`default_nettype wire

// ### bes_pkg.sv
// Package with constants and types for the back-EMF sampling controller
package bes_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] BES_ADDR_CTRL_A   = 4'h0; // control_reg_a
  localparam logic [3:0] BES_ADDR_CTRL_C   = 4'h1; // control_reg_c
  localparam logic [3:0] BES_ADDR_CONF     = 4'h2; // sampling_config_reg
  localparam logic [3:0] BES_ADDR_SCTRL    = 4'h3; // sampling_control_reg
  localparam logic [3:0] BES_ADDR_ZFILT    = 4'h4; // zc_filter_reg
  localparam logic [3:0] BES_ADDR_PWMTIM   = 4'h5; // window and off-time
  localparam logic [3:0] BES_ADDR_CMP_LO   = 4'h6; // compare value low
  localparam logic [3:0] BES_ADDR_CMP_HI   = 4'h7; // compare value high
  localparam logic [3:0] BES_ADDR_STATUS   = 4'h8; // read-only status
  // Field positions
  localparam int BES_A_MOE     = 0;  // phase_output_enable
  localparam int BES_A_SR      = 1;  // sensor_mode_select
  localparam int BES_A_CURMODE = 2;  // current mode when set
  localparam int BES_A_HSEL    = 3;  // rotor input select, 2 bits
  localparam int BES_C_HR      = 0;  // high_rate_zc_sampling
  localparam int BES_C_SCF     = 1;  // sample clock select, 2 bits
  localparam int BES_C_ZLVL    = 3;  // expected comparator level
  localparam int BES_CONF_DS   = 0;  // sample_delay_select, 4 bits
  localparam int BES_CONF_SOM  = 6;  // sample_out_int_mask
  localparam int BES_CONF_SOF  = 7;  // sample_out_flag
  localparam int BES_S_ZSV     = 0;  // zc_sampling_when_idle
  localparam int BES_S_OFF_INPUT_STATE_SELECT    = 1;  // off_input_state_select
  // Reset values
  localparam logic [7:0]  BES_RST_REG = 8'h00;
  localparam logic [11:0] BES_RST_CMP = 12'h000;
  // Timing
  localparam int BES_PERIPH_MHZ  = 4;     // peripheral_clock_freq
  localparam int BES_DS_STEP_NS  = 2500;  // one delay step
  localparam int BES_DS_STEP_CYC = (BES_DS_STEP_NS * BES_PERIPH_MHZ) / 1000;
  localparam logic [7:0]  BES_DS_STEP   = 8'(BES_DS_STEP_CYC);
  localparam logic [8:0]  BES_WIN_STEP  = 9'h010; // window step, cycles
  localparam logic [5:0]  BES_OFF_STEP  = 6'h04;  // off-time step, cycles
  localparam logic [11:0] BES_PWM_MAX   = 12'hfff;
  localparam logic [4:0]  BES_SCF_DIV0  = 5'h03;  // sample_clock_freq tick
  // Phase of the commutation step
  typedef enum logic [1:0] {
    PH_DEMAG = 2'b00,  // waiting for end of demagnetisation
    PH_ZC    = 2'b01,  // searching zero crossing
    PH_DONE  = 2'b10   // zero crossing found, wait commutation
  } bes_phase_t;
  // Whole state of the controller
  typedef struct packed {
    logic [4:0]  sync1;     // first synchroniser stage
    logic [4:0]  sync2;     // second synchroniser stage
    logic [4:0]  ctl_a;     // control_reg_a
    logic [3:0]  ctl_c;     // control_reg_c
    logic [3:0]  dly;       // sample_delay_select
    logic        sample_out_int_mask;       // sample_out_int_mask
    logic        sof;       // sample_out_flag
    logic [1:0]  sctl;      // sampling_control_reg
    logic [3:0]  zef;       // zc_event_filter_count
    logic [3:0]  win_sel;   // measurement_window_select
    logic [3:0]  off_sel;   // min_off_time_select
    logic [11:0] cmp;       // voltage-mode compare value
    logic [7:0]  rdata;     // read data
    bes_phase_t  phase;     // step phase
    logic [11:0] vcnt;      // voltage-mode PWM counter
    logic [8:0]  wcnt;      // measurement window counter
    logic [5:0]  ocnt;      // minimum off-time counter
    logic        lim;       // current limit latched this period
    logic        pwm;       // PWM signal
    logic        pwm_prev;  // PWM one cycle ago
    logic [7:0]  dcnt;      // sample delay counter
    logic        dly_run;   // delay in progress
    logic        on_ok;     // PWM stayed on during delay
    logic        win_open;  // high-rate window after delay
    logic [4:0]  scf_cnt;   // sample clock divider
    logic [3:0]  zcnt;      // consecutive matching samples
    logic        d_smp;     // demag sample strobe
    logic        z_smp;     // zero-crossing sample strobe
    logic        z_evt;     // zero-crossing event
    logic        irq;       // sample-out interrupt
    logic        gnd;       // ground off-state inputs
    logic        hiz;       // float off-state inputs
  } bes_state_t;
endpackage : bes_pkg

// ### bes_motor_model.sv
// Far-side model: phase comparator, Hall sensors and current comparator
`timescale 1ns/10ps
`default_nettype none
module bes_motor_model (
  input  wire logic i_level,  // Commanded back-EMF polarity
  input  wire logic i_limit,  // Commanded current limit state
  output logic      o_cmp,    // Phase comparator output
  output logic      o_hall_a, // Hall sensor a
  output logic      o_hall_b, // Hall sensor b
  output logic      o_hall_c, // Hall sensor c
  output logic      o_cur     // Current comparator output
);
  // Phase comparator follows the motor level; Hall b sits opposite to a and c
  assign o_cmp    = i_level;
  assign o_hall_a = i_level;
  assign o_hall_b = ~i_level;
  assign o_hall_c = i_level;
  assign o_cur    = i_limit;
endmodule : bes_motor_model
`default_nettype wire

// ### test_bemf_event_sampling_control.sv
// Self-checking bench for the back-EMF sampling controller
`timescale 1ns/10ps
`default_nettype none
module test_bemf_event_sampling_control;
  import bes_pkg::*;
  // One register row: index, write value, read-back, off-input pins
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] w;
    logic [7:0] r;
    logic       g;
    logic       h;
  } bes_row_t;
  localparam bes_row_t ROWS [12] = '{
    {4'h3, 8'h00, 8'h00, 1'b1, 1'b0}, {4'h3, 8'h02, 8'h02, 1'b0, 1'b1},
    {4'h1, 8'h01, 8'h01, 1'b0, 1'b0}, {4'h1, 8'h00, 8'h00, 1'b0, 1'b1},
    {4'h2, 8'h01, 8'h01, 1'b0, 1'b0}, {4'h2, 8'h00, 8'h00, 1'b0, 1'b1},
    {4'h4, 8'hff, 8'h0f, 1'b0, 1'b1}, {4'h5, 8'ha5, 8'ha5, 1'b0, 1'b1},
    {4'h7, 8'h02, 8'h02, 1'b0, 1'b1}, {4'h9, 8'hff, 8'h00, 1'b0, 1'b1},
    {4'h0, 8'hff, 8'h1f, 1'b0, 1'b0}, {4'h0, 8'h00, 8'h00, 1'b0, 1'b1}};
  logic       clk, arst_n, wr_s, rd_s, cmt, dmg, lvl, lim; // Bench drives
  logic [3:0] addr;      // Register index
  logic [7:0] wdata;     // Write data
  logic [7:0] rdata;     // Read data
  logic [3:0] zcnt;      // Consecutive match count
  logic       pwm, ds, zs, ze, irq, gnd, hiz;  // Design outputs
  logic       pcmp, ha, hb, hc, cur;           // Model pins
  int         errors, total_checks, nds, nzs, n0, n1, c1, c2, i;
  // Clock, 100 MHz
  always #5 clk = ~clk;
  // Strobe counters, sampled mid-cycle where outputs are settled
  always @(negedge clk) begin
    if (ds === 1'b1) nds++;
    if (zs === 1'b1) nzs++;
  end
  bes_motor_model i_model (.i_level(lvl), .i_limit(lim), .o_cmp(pcmp),
    .o_hall_a(ha), .o_hall_b(hb), .o_hall_c(hc), .o_cur(cur));
  bes_sampling_ctrl i_dut (.i_ref_clk(clk), .i_arst_n(arst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
    .i_phase_cmp(pcmp), .i_rotor_input_a(ha), .i_rotor_input_b(hb),
    .i_rotor_input_c(hc), .i_cur_limit(cur), .i_commutate(cmt),
    .i_demag_event(dmg), .o_rdata(rdata), .o_pwm(pwm), .o_d_sample(ds),
    .o_z_sample(zs), .o_zc_event(ze), .o_zc_count(zcnt),
    .o_sample_out_irq(irq), .o_off_input_ground(gnd),
    .o_off_input_hiz(hiz));
  // Verdict and end of run
  task automatic print_verdict;
    if (errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // Compare and count
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // A used-up wait bound counts as a mismatch and ends the run
  task automatic tmo(input int k, input int lim_k);
    if (k >= lim_k) begin
      errors++;
      print_verdict();
    end
  endtask : tmo
  // Register write, one cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  // Register read, data checked in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  // One-cycle commutation (c=1) or demagnetisation (c=0) pulse
  task automatic pulse(input logic c);
    @(posedge clk);
    if (c) cmt <= 1'b1;
    else dmg <= 1'b1;
    @(posedge clk);
    cmt <= 1'b0;
    dmg <= 1'b0;
  endtask : pulse
  // Cycles from a PWM turn-on to the delayed zero-crossing sample
  task automatic meas(input logic [3:0] d, output int c);
    wr(BES_ADDR_CONF, {4'h0, d});
    // Step off the edge that updates the outputs
    #1;
    for (i = 0; i < 9000 && pwm !== 1'b0; i++) @(posedge clk) #1;
    for (; i < 9000 && pwm !== 1'b1; i++) @(posedge clk) #1;
    n0 = nzs;
    for (c = 0; i < 9000 && nzs == n0; i++) begin
      @(posedge clk) #1;
      c++;
    end
    tmo(i, 9000);
    chk(pwm, 1'b1);
  endtask : meas
  // Hang guard
  initial begin
    #1000000;
    errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    {clk, arst_n, wr_s, rd_s, cmt, dmg, lvl, lim} = 8'h00;
    {addr, wdata, errors, total_checks, nds, nzs} = '0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    #1 chk({pwm, ds, zs, ze, irq}, 12'h000);
    for (int k = 0; k < 8; k++) rd(4'(k), BES_RST_REG);
    // Register rows with off-input pin levels
    for (int k = 0; k < 12; k++) begin
      wr(ROWS[k].a, ROWS[k].w);
      rd(ROWS[k].a, ROWS[k].r);
      chk(gnd, ROWS[k].g);
      chk(hiz, ROWS[k].h);
    end
    // Voltage mode, half duty; no Z samples before the demag event
    lvl <= 1'b1;
    wr(BES_ADDR_CTRL_A, 8'h01);
    wr(BES_ADDR_CMP_LO, 8'h00);
    wr(BES_ADDR_CMP_HI, 8'h08);
    pulse(1'b1);
    n0 = nzs;
    repeat (4200) @(posedge clk);
    chk(12'(nzs - n0), 12'h000);
    pulse(1'b0);
    // Delay steps of ten cycles, one sample a period
    meas(4'h1, c1);
    meas(4'hf, c2);
    chk(12'(c2 - c1), 12'h08c);
    n0 = nzs;
    repeat (4096) @(posedge clk);
    chk(12'(nzs - n0), 12'h001);
    // Delay beyond on-time: discarded sample, flag and interrupt
    wr(BES_ADDR_CMP_HI, 8'h00);
    wr(BES_ADDR_CMP_LO, 8'h10);
    wr(BES_ADDR_CONF, 8'h4f);
    n0 = nzs;
    for (i = 0; i < 9000 && irq !== 1'b1; i++) @(posedge clk) #1;
    tmo(i, 9000);
    chk(12'(nzs - n0), 12'h000);
    rd(BES_ADDR_CONF, 8'hcf);
    wr(BES_ADDR_CONF, 8'hc0);
    repeat (2) @(posedge clk) #1;
    chk(irq, 1'b0);
    wr(BES_ADDR_CONF, 8'h40);
    rd(BES_ADDR_CONF, 8'h40);
    // High rate: demag samples, then filtered Z event after three matches
    lvl <= 1'b0;
    wr(BES_ADDR_CONF, 8'h00);
    wr(BES_ADDR_CTRL_C, 8'h01);
    wr(BES_ADDR_ZFILT, 8'h02);
    n0 = nds;
    pulse(1'b1);
    repeat (40) @(posedge clk);
    chk(nds > n0, 1'b1);
    pulse(1'b0);
    n0 = nzs;
    // First matching sample moves the count to one
    for (i = 0; i < 2000 && zs !== 1'b1; i++) @(negedge clk);
    tmo(i, 2000);
    chk(zcnt, 4'h1);
    for (i = 0; i < 2000 && ze !== 1'b1; i++) @(negedge clk);
    tmo(i, 2000);
    #1 chk(12'(nzs - n0), 12'h003);
    chk(zcnt, 4'h0);
    // Hall mode: no demag sampling, Z samples at the sample clock
    wr(BES_ADDR_CTRL_A, 8'h03);
    pulse(1'b1);
    n0 = nds;
    n1 = nzs;
    repeat (40) @(posedge clk);
    chk(12'(nds - n0), 12'h000);
    chk(nzs > n1, 1'b1);
    // Current mode: limit forces PWM off, window start turns it on
    wr(BES_ADDR_CTRL_A, 8'h05);
    lim <= 1'b1;
    repeat (4) @(posedge clk) #1;
    chk(pwm, 1'b0);
    lim <= 1'b0;
    for (i = 0; i < 300 && pwm !== 1'b1; i++) @(posedge clk) #1;
    tmo(i, 300);
    chk(pwm, 1'b1);
    // Second reset in mid-run
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({pwm, ds, zs, ze, irq, gnd, hiz}, 12'h000);
    arst_n <= 1'b1;
    rd(BES_ADDR_CTRL_A, BES_RST_REG);
    print_verdict();
  end
endmodule : test_bemf_event_sampling_control
`default_nettype wire
